//--- verilog/imp_pkg.sv
// package: opcodes, field layout, widths and states for the indexed move and pointer unit
package imp_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam int OFFS_W = 7;
   localparam int SUBK_W = 6;
   // opcode patterns in the upper bits of the instruction word
   localparam logic [7:0] OP_IDX_MOVE = 8'hEB;
   localparam logic [7:0] OP_PUSH_LIT = 8'hFA;
   localparam logic [7:0] OP_PTR_SUB = 8'hE9;
   localparam logic [3:0] OP_SECOND = 4'hF;
   localparam int IDX_KIND_BIT = 7;
   localparam logic [1:0] PTR_SEL_MAX = 2'h2;
   localparam logic [1:0] PTR_SEL_FP2 = 2'h2;
   // indirect-addressing register window (top of data space)
   localparam logic [ADDR_W-1:0] INDIR_BASE = 12'hFDB;
   localparam logic [ADDR_W-1:0] INDIR_LAST = 12'hFEF;
   localparam logic [ADDR_W-1:0] INDIR_STEP = 12'h008;
   localparam logic [2:0] INDIR_MASK_LOW = 3'h7;
   localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [ADDR_W-1:0] ONE_ADDR = 12'h001;
   typedef enum logic [1:0] {IMP_IDLE, IMP_SECOND} imp_state_e;
   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] word;
   } imp_fetch_s;
   typedef struct packed {
      logic rd_en;
      logic [ADDR_W-1:0] rd_addr;
      logic wr_en;
      logic [ADDR_W-1:0] wr_addr;
      logic [DATA_W-1:0] wr_data;
   } imp_mem_s;
endpackage

//--- verilog/imp_ptr_bank.sv
// file-select pointer bank with literal subtract and push post-decrement
`timescale 1ns/1ps
module imp_ptr_bank #(
   parameter int NUM_PTR = 3
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sub_en,
   input wire logic [1:0] sub_sel,
   input wire logic [imp_pkg::SUBK_W-1:0] sub_k,
   input wire logic dec_en,
   output logic [imp_pkg::ADDR_W-1:0] ptr_q [NUM_PTR]
);
   initial begin
      if (NUM_PTR != 3) $error("pointer bank needs exactly three pointers");
   end
   ////////////////////////////////////////////////////////////////////////
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PTR; gi++) begin : g_ptr
         wire logic hit_sub = sub_en && (sub_sel == 2'(gi));
         wire logic hit_dec = dec_en && (2'(gi) == imp_pkg::PTR_SEL_FP2);
         // plain 12-bit wrap; no status flag is touched
         wire logic [imp_pkg::ADDR_W-1:0] sub_d = ptr_q[gi] - {6'h00, sub_k};
         wire logic [imp_pkg::ADDR_W-1:0] dec_d = ptr_q[gi] - imp_pkg::ONE_ADDR;
         always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               ptr_q[gi] <= imp_pkg::PTR_RST;
            end else if (hit_sub) begin
               ptr_q[gi] <= sub_d;
            end else if (hit_dec) begin
               ptr_q[gi] <= dec_d;
            end
         end
      end
   endgenerate
endmodule

//--- verilog/imp_exec.sv
// execution unit for indexed moves, literal push and pointer subtract
`timescale 1ns/1ps
module imp_exec (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire imp_pkg::imp_fetch_s fetch,
   input wire logic [imp_pkg::DATA_W-1:0] mem_rd_data,
   output imp_pkg::imp_mem_s mem,
   output logic busy,
   output logic [imp_pkg::ADDR_W-1:0] frame_pointer_two,
   output logic [imp_pkg::ADDR_W-1:0] file_select_pointer_zero,
   output logic [imp_pkg::ADDR_W-1:0] file_select_pointer_one
);
   // three groups of five at the top of data space; the low three slots of each group are plain registers
   function automatic logic is_indirect(input logic [imp_pkg::ADDR_W-1:0] a);
      is_indirect = (a >= imp_pkg::INDIR_BASE) && (a <= imp_pkg::INDIR_LAST)
                    && (a[2:0] >= imp_pkg::INDIR_BASE[2:0]);
   endfunction
   ////////////////////////////////////////////////////////////////////////
   logic [imp_pkg::ADDR_W-1:0] ptr_q [3];
   imp_pkg::imp_state_e state_q, state_d;
   logic kind_idx_q;
   logic [imp_pkg::ADDR_W-1:0] src_addr_q;
   logic [imp_pkg::DATA_W-1:0] src_data_q;
   logic rd_pend_q;
   imp_pkg::imp_mem_s mem_d;
   wire logic [15:0] w = fetch.word;
   wire logic first_move = fetch.valid && state_q == imp_pkg::IMP_IDLE && w[15:8] == imp_pkg::OP_IDX_MOVE;
   wire logic second_ok = fetch.valid && state_q == imp_pkg::IMP_SECOND && w[15:12] == imp_pkg::OP_SECOND;
   wire logic is_push = fetch.valid && state_q == imp_pkg::IMP_IDLE && w[15:8] == imp_pkg::OP_PUSH_LIT;
   wire logic is_sub = fetch.valid && state_q == imp_pkg::IMP_IDLE && w[15:8] == imp_pkg::OP_PTR_SUB
                       && w[7:6] <= imp_pkg::PTR_SEL_MAX;
   wire logic [imp_pkg::ADDR_W-1:0] fp2 = ptr_q[imp_pkg::PTR_SEL_FP2];
   wire logic [imp_pkg::ADDR_W-1:0] src_d = fp2 + {5'h00, w[imp_pkg::OFFS_W-1:0]};
   wire logic [imp_pkg::ADDR_W-1:0] dst_idx = fp2 + {5'h00, w[imp_pkg::OFFS_W-1:0]};
   wire logic [imp_pkg::ADDR_W-1:0] dst_abs = w[imp_pkg::ADDR_W-1:0];
   wire logic [imp_pkg::ADDR_W-1:0] dst = kind_idx_q ? dst_idx : dst_abs;
   wire logic src_ind = is_indirect(src_d);
   wire logic write_ok = second_ok && !(kind_idx_q && is_indirect(dst_idx));
   // destination of program counter or return bytes is not guarded here
   always_comb begin
      state_d = state_q;
      case (state_q)
         imp_pkg::IMP_IDLE: if (first_move) state_d = imp_pkg::IMP_SECOND;
         imp_pkg::IMP_SECOND: if (fetch.valid) state_d = imp_pkg::IMP_IDLE;
         default: state_d = imp_pkg::IMP_IDLE;
      endcase
   end
   always_comb begin
      mem_d = '0;
      mem_d.rd_en = first_move && !src_ind;
      mem_d.rd_addr = src_d;
      if (is_push) begin
         mem_d.wr_en = 1'b1;
         mem_d.wr_addr = fp2;
         mem_d.wr_data = w[7:0];
      end else if (write_ok) begin
         mem_d.wr_en = 1'b1;
         mem_d.wr_addr = dst;
         mem_d.wr_data = src_data_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= imp_pkg::IMP_IDLE;
         kind_idx_q <= 1'b0;
         src_addr_q <= imp_pkg::PTR_RST;
         src_data_q <= imp_pkg::ZERO_BYTE;
         rd_pend_q <= 1'b0;
         mem <= '0;
      end else begin
         state_q <= state_d;
         mem <= mem_d;
         if (first_move) begin
            kind_idx_q <= w[imp_pkg::IDX_KIND_BIT];
            src_addr_q <= src_d;
         end
         // read data stands one cycle after the registered request, so track the request one more edge
         rd_pend_q <= mem.rd_en;
         // an indirect source never issues a read and keeps the zero loaded here
         if (first_move) src_data_q <= imp_pkg::ZERO_BYTE;
         else if (rd_pend_q) src_data_q <= mem_rd_data;
      end
   end
   assign busy = state_q == imp_pkg::IMP_SECOND;
   imp_ptr_bank #(.NUM_PTR(3)) u_ptr (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .sub_en(is_sub),
      .sub_sel(w[7:6]),
      .sub_k(w[imp_pkg::SUBK_W-1:0]),
      .dec_en(is_push),
      .ptr_q(ptr_q)
   );
   assign file_select_pointer_zero = ptr_q[0];
   assign file_select_pointer_one = ptr_q[1];
   assign frame_pointer_two = ptr_q[2];
   ////////////////////////////////////////////////////////////////////////
   sequence s_push;
      is_push;
   endsequence
   property p_push_write;
      @(posedge sys_clk) disable iff (sys_rst)
      s_push |=> mem.wr_en && mem.wr_addr == $past(fp2) && mem.wr_data == $past(w[7:0]);
   endproperty
   a_push_write: assert property (p_push_write) else $error("push write wrong");
   property p_push_dec;
      @(posedge sys_clk) disable iff (sys_rst)
      is_push |=> frame_pointer_two == $past(fp2) - imp_pkg::ONE_ADDR;
   endproperty
   a_push_dec: assert property (p_push_dec) else $error("push decrement wrong");
   property p_sub;
      @(posedge sys_clk) disable iff (sys_rst)
      is_sub && w[7:6] == 2'h0_0 |=> file_select_pointer_zero == $past(ptr_q[0]) - 12'($past(w[5:0]));
   endproperty
   a_sub: assert property (p_sub) else $error("subtract wrong");
   property p_sub_decode;
      @(posedge sys_clk) disable iff (sys_rst)
      fetch.valid && !busy && w[15:8] != imp_pkg::OP_PTR_SUB && w[15:8] != imp_pkg::OP_PUSH_LIT
         |=> $stable(frame_pointer_two) && $stable(file_select_pointer_zero) && $stable(file_select_pointer_one);
   endproperty
   a_sub_decode: assert property (p_sub_decode) else $error("subtract decode wrong");
   property p_abs_dst;
      @(posedge sys_clk) disable iff (sys_rst)
      second_ok && !kind_idx_q |=> mem.wr_en && mem.wr_addr == $past(w[11:0]);
   endproperty
   a_abs_dst: assert property (p_abs_dst) else $error("absolute destination wrong");
   property p_src_rd;
      @(posedge sys_clk) disable iff (sys_rst)
      first_move && !src_ind |=> mem.rd_en && mem.rd_addr == $past(fp2) + 12'($past(w[6:0]));
   endproperty
   a_src_rd: assert property (p_src_rd) else $error("source address wrong");
   property p_ind_nop;
      @(posedge sys_clk) disable iff (sys_rst)
      second_ok && kind_idx_q && is_indirect(dst_idx) |=> !mem.wr_en;
   endproperty
   a_ind_nop: assert property (p_ind_nop) else $error("indirect destination written");
   property p_ind_src;
      @(posedge sys_clk) disable iff (sys_rst)
      first_move && src_ind |=> src_data_q == imp_pkg::ZERO_BYTE && !mem.rd_en;
   endproperty
   a_ind_src: assert property (p_ind_src) else $error("indirect source not zero");
   ////////////////////////////////////////////////////////////////////////
   // move sequencing: first word, wait, second word
   sequence s_move_first;
      first_move;
   endsequence
   sequence s_second_word;
      second_ok;
   endsequence
   property p_move_busy;
      @(posedge sys_clk) disable iff (sys_rst)
      s_move_first |=> busy && !mem.wr_en;
   endproperty
   a_move_busy: assert property (p_move_busy) else $error("move did not wait for second word");
   property p_idx_dst;
      @(posedge sys_clk) disable iff (sys_rst)
      s_second_word ##0 (kind_idx_q && !is_indirect(dst_idx)) |=> mem.wr_en && mem.wr_addr == $past(dst_idx)
         && mem.wr_data == $past(src_data_q);
   endproperty
   a_idx_dst: assert property (p_idx_dst) else $error("indexed destination wrong");
   property p_src_capture;
      @(posedge sys_clk) disable iff (sys_rst)
      rd_pend_q && !first_move |=> src_data_q == $past(mem_rd_data);
   endproperty
   a_src_capture: assert property (p_src_capture) else $error("source byte not captured");
   // a second word of the wrong kind ends the move with nothing written
   property p_bad_second;
      @(posedge sys_clk) disable iff (sys_rst)
      fetch.valid && busy && w[15:12] != imp_pkg::OP_SECOND |=> !mem.wr_en && !busy;
   endproperty
   a_bad_second: assert property (p_bad_second) else $error("bad second word not dropped");
   ////////////////////////////////////////////////////////////////////////
   // pointer arithmetic
   property p_sub_any;
      @(posedge sys_clk) disable iff (sys_rst)
      is_sub |=> ptr_q[$past(w[7:6])] == $past(ptr_q[w[7:6]]) - 12'($past(w[5:0]));
   endproperty
   a_sub_any: assert property (p_sub_any) else $error("subtract on selected pointer wrong");
   property p_sub_ignore;
      @(posedge sys_clk) disable iff (sys_rst)
      fetch.valid && !busy && w[15:8] == imp_pkg::OP_PTR_SUB && w[7:6] > imp_pkg::PTR_SEL_MAX
         |=> $stable(frame_pointer_two) && $stable(file_select_pointer_zero) && $stable(file_select_pointer_one);
   endproperty
   a_sub_ignore: assert property (p_sub_ignore) else $error("invalid selector changed a pointer");
   property p_push_keep;
      @(posedge sys_clk) disable iff (sys_rst)
      is_push |=> $stable(file_select_pointer_zero) && $stable(file_select_pointer_one);
   endproperty
   a_push_keep: assert property (p_push_keep) else $error("push touched another pointer");
endmodule

//--- tb/imp_mem_model.sv
// memory partner: byte writes, registered read answered one cycle after the request
`timescale 1ns/1ps
module imp_mem_model (
   input wire logic sys_clk,
   input wire imp_pkg::imp_mem_s mem,
   output logic [imp_pkg::DATA_W-1:0] rd_data
);
   logic [imp_pkg::DATA_W-1:0] ram [1 << imp_pkg::ADDR_W];
   initial rd_data = 8'hA5;
   // read data holds only one cycle, then flips so a late capture never sees stale data
   always @(posedge sys_clk) begin
      if (mem.rd_en) begin
         rd_data <= ram[mem.rd_addr];
      end else begin
         rd_data <= ~rd_data;
      end
      if (mem.wr_en) begin
         ram[mem.wr_addr] <= mem.wr_data;
      end
   end
endmodule

//--- tb/test_imp_exec.sv
// self-checking bench for the indexed move and pointer unit
`timescale 1ns/1ps
module test_imp_exec;
   logic sys_clk;
   logic sys_rst;
   imp_pkg::imp_fetch_s fetch;
   logic [imp_pkg::DATA_W-1:0] mem_rd_data;
   imp_pkg::imp_mem_s mem;
   logic busy;
   logic [imp_pkg::ADDR_W-1:0] fp2, fsp0, fsp1;
   logic [imp_pkg::ADDR_W-1:0] ep [3];
   int err_count = 0;
   int checked = 0;
   imp_exec u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .fetch(fetch), .mem_rd_data(mem_rd_data), .mem(mem),
      .busy(busy), .frame_pointer_two(fp2), .file_select_pointer_zero(fsp0), .file_select_pointer_one(fsp1));
   imp_mem_model u_mem (.sys_clk(sys_clk), .mem(mem), .rd_data(mem_rd_data));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one word per call; returns one step after the taking edge, where the answer stands
   task automatic issue(input logic [15:0] w);
      @(posedge sys_clk);
      fetch <= '{valid: 1'b1, word: w};
      @(posedge sys_clk);
      fetch <= '0;
      #1;
   endtask
   task automatic move(input logic idx, input logic [6:0] zs, input logic [11:0] dst, input logic ew,
                       input logic [11:0] ea, input logic [7:0] ed, input logic er);
      logic [11:0] sa;
      sa = ep[2] + zs;
      issue({imp_pkg::OP_IDX_MOVE, idx, zs});
      chk("busy", 16'h0001, busy);
      chk("rd_en", er, mem.rd_en);
      if (er) chk("rd_addr", sa, mem.rd_addr);
      // idle cycle lets the read answer land before the second word
      @(posedge sys_clk);
      issue({imp_pkg::OP_SECOND, dst});
      chk("wr_en", ew, mem.wr_en);
      if (ew) begin
         chk("wr_addr", ea, mem.wr_addr);
         chk("wr_data", ed, mem.wr_data);
      end
   endtask
   task automatic wrap_up;
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_push;
      issue({imp_pkg::OP_PUSH_LIT, 8'h5A});
      chk("push wr_en", 16'h0001, mem.wr_en);
      chk("push addr", ep[2], mem.wr_addr);
      chk("push data", 16'h005A, mem.wr_data);
      ep[2] = ep[2] - 12'h001;
      chk("push fp2", ep[2], fp2);
   endtask
   task automatic t_sub;
      logic [5:0] k;
      for (int s = 0; s < 4; s++) begin
         k = (s == 0) ? 6'h01 : 6'h3F;
         issue({imp_pkg::OP_PTR_SUB, 2'(s), k});
         if (s < 3) ep[s] = ep[s] - k;
         chk("fsp0", ep[0], fsp0);
         chk("fsp1", ep[1], fsp1);
         chk("fp2", ep[2], fp2);
      end
   endtask
   task automatic t_abs_move;
      u_mem.ram[12'hFC5] = 8'h33;
      move(1'b0, 7'h05, 12'h123, 1'b1, 12'h123, 8'h33, 1'b1);
      move(1'b0, 7'h05, 12'hFFF, 1'b1, 12'hFFF, 8'h33, 1'b1);
      u_mem.ram[12'hFE0] = 8'h44;
      move(1'b0, 7'h20, 12'h202, 1'b1, 12'h202, 8'h44, 1'b1);
   endtask
   task automatic t_indir_src;
      u_mem.ram[12'hFEF] = 8'h77;
      move(1'b0, 7'h2F, 12'h200, 1'b1, 12'h200, 8'h00, 1'b0);
      move(1'b1, 7'h2F, 12'h006, 1'b1, 12'hFC6, 8'h00, 1'b0);
      move(1'b0, 7'h1F, 12'h201, 1'b1, 12'h201, 8'h00, 1'b0);
   endtask
   task automatic t_idx_move;
      move(1'b1, 7'h05, 12'hF86, 1'b1, 12'hFC6, 8'h33, 1'b1);
      move(1'b1, 7'h05, 12'h027, 1'b0, 12'h000, 8'h00, 1'b1);
   endtask
   task automatic t_bad_second;
      issue({imp_pkg::OP_IDX_MOVE, 1'b0, 7'h05});
      @(posedge sys_clk);
      issue(16'h0123);
      chk("bad second wr_en", 16'h0000, mem.wr_en);
      chk("bad second busy", 16'h0000, busy);
   endtask
   task automatic t_reset;
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      ep = '{default: imp_pkg::PTR_RST};
      chk("reset fp2", ep[2], fp2);
      chk("reset fsp0", ep[0], fsp0);
      chk("reset busy", 16'h0000, busy);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      fetch = '0;
      ep = '{default: imp_pkg::PTR_RST};
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_push();
      t_sub();
      t_abs_move();
      t_indir_src();
      t_idx_move();
      t_bad_second();
      t_reset();
      t_push();
      wrap_up();
   end
   // the sequence needs well under a hundred cycles
   initial begin
      repeat (2000) @(posedge sys_clk);
      err_count++;
      wrap_up();
   end
endmodule
